// file: tb_top.sv
// tb_top.sv: self-checking bench of the wake-up watchdog timer
// assumes checker and host model compiled first; ticks of 8 mclk
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
	localparam int TK = 8;
	logic mclk = 1'b0, host_reset_n = 1'b0, mrPin = 1'b0, measDone = 1'b0;
	logic [19:0] measCode = 20'h0;
	logic [1:0] mode = 2'h0;
	logic [7:0] dly = 8'h05;
	wire logic doneIn, wake, rOut, rOeN, measEn, toDig;
	int err_count = 0, checked = 0, ivl, c, c2;
	integer seed = 32'h5963;
	always #25 mclk = ~mclk;
	wwt_top #(.TICK_CYCLES(TK)) u_dut (.mclk(mclk), .host_reset_n(host_reset_n), .ce(1'b1),
		.doneIn(doneIn), .mrPin(mrPin), .measDone(measDone), .measCode(measCode),
		.wake(wake), .hostResetNOut(rOut), .hostResetNOeN(rOeN), .measEn(measEn),
		.pinToDigital(toDig));
	wwt_host_model u_host (.mclk(mclk), .wake(wake), .mode(mode), .dly(dly), .doneIn(doneIn));
	// one tick of slack: async events land anywhere inside a tick
	function automatic logic near(int n, int e);
		return n >= e - TK && n <= e + TK;
	endfunction
	task automatic wait_on(int s, logic lvl, output int n);
		for (n = 1; n < 4000; n++) begin
			@(posedge mclk);
			if ((s == 0 ? wake : s == 1 ? rOeN : measEn) === lvl) return;
		end
		`CHK(1'b0, 1'b1, "wait too long")
	endtask
	task automatic rst_cycle(int hold);
		wait_on(1, 1'b1, c);
		`CHK(near(c, hold), 1'b1, "reset width")
		wait_on(0, 1'b1, c);
		`CHK(near(c, ivl * TK), 1'b1, "first wake")
	endtask
	task automatic period(int skip = 0);
		wait_on(0, 1'b0, c);
		wait_on(0, 1'b1, c2);
		`CHK(c + c2, ivl * TK - skip, "wake period")
		`CHK(rOeN, 1'b1, "no reset")
	endtask
	task automatic meas_run(int code);
		ivl = code < 10 ? 10 : code;
		wait_on(2, 1'b1, c);
		`CHK(toDig, 1'b0, "pin path")
		repeat (3 + {$random(seed)} % 40) @(posedge mclk);
		measDone <= 1'b1;
		measCode <= code[19:0];
		@(posedge mclk);
		measDone <= 1'b0;
		wait_on(2, 1'b0, c);
		`CHK({toDig, rOeN}, 2'b10, "after measure")
		rst_cycle(32 * TK);
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		`CHK({wake, rOeN, measEn}, 3'b000, "in reset")
		host_reset_n <= 1'b1;
		meas_run(10 + {$random(seed)} % 4);
		for (int i = 0; i < 4; i++) begin
			mode <= 2'(i % 2);
			dly <= 8'(3 + {$random(seed)} % 40);
			period();
		end
		dly <= 8'(ivl * TK - 12);
		period();
		wait_on(1, 1'b0, c);
		`CHK({near(c, ivl * TK), wake, measEn}, 3'b100, "late ack")
		mode <= 2'h2;
		rst_cycle(32 * TK);
		wait_on(1, 1'b0, c);
		`CHK(near(c, ivl * TK), 1'b1, "level ack")
		mode <= 2'h0;
		dly <= 8'h05;
		rst_cycle(32 * TK);
		mrPin <= 1'b1;
		repeat (6) @(posedge mclk);
		mrPin <= 1'b0;
		period(6);
		mrPin <= 1'b1;
		repeat (3 * TK + {$random(seed)} % (2 * TK)) @(posedge mclk);
		`CHK({rOeN, wake, measEn}, 3'b000, "manual reset")
		mrPin <= 1'b0;
		rst_cycle(34 * TK + TK / 2);
		period();
		host_reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		host_reset_n <= 1'b1;
		wait_on(2, 1'b1, c);
		mrPin <= 1'b1;
		repeat (3 * TK) @(posedge mclk);
		`CHK(measEn, 1'b0, "abort")
		mrPin <= 1'b0;
		wait_on(2, 1'b1, c);
		`CHK(c < 3 * TK, 1'b1, "restart")
		meas_run(3);
		period();
		print_verdict();
	end
	initial begin
		#(40000 * 50);
		err_count++;
		print_verdict();
	end
endmodule // tb_top
bind wwt_top wwt_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk(mclk), .host_reset_n(host_reset_n),
	.doneIn(doneIn), .mrPin(mrPin), .wake(wake), .hostResetNOut(hostResetNOut),
	.hostResetNOeN(hostResetNOeN), .measEn(measEn), .pinToDigital(pinToDigital));
`default_nettype wire

// file: wwt_chk_assertions.sv
// wwt_chk_assertions.sv: port checks of the wake-up watchdog timer
// assumes ce held high, so every mclk edge is a working edge
`timescale 1ns/1ps
`default_nettype none
module wwt_chk #(
	parameter TICK_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic host_reset_n,
	input wire logic doneIn,
	input wire logic mrPin,
	input wire logic wake,
	input wire logic hostResetNOut,
	input wire logic hostResetNOeN,
	input wire logic measEn,
	input wire logic pinToDigital
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!host_reset_n);
	// run lengths in cycles: long holds exceed what a repetition may span
	int lowCnt_reg, mrCnt_reg, wakeCnt_reg;
	always_ff @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			lowCnt_reg <= 0;
			mrCnt_reg <= 0;
			wakeCnt_reg <= 0;
		end else begin
			lowCnt_reg <= hostResetNOeN ? 0 : lowCnt_reg + 1;
			mrCnt_reg <= mrPin ? mrCnt_reg + 1 : 0;
			wakeCnt_reg <= wake ? wakeCnt_reg + 1 : 0;
		end
	end
	a_od_low: assert property (hostResetNOut == 1'b0) else $error("reset data high");
	a_pin_route: assert property (pinToDigital == !measEn) else $error("pin route");
	a_meas_rst: assert property (measEn |-> !hostResetNOeN) else $error("meas no reset");
	a_wake_rst: assert property (wake |-> hostResetNOeN) else $error("wake in reset");
	a_ack_cut: assert property (wake && $rose(doneIn) |=> !wake) else $error("ack cut");
	a_wake_width: assert property (wakeCnt_reg <= 2 * TICK_CYCLES + 1)
		else $error("wake too long");
	a_rst_width: assert property ($rose(hostResetNOeN) |-> lowCnt_reg >= 32 * TICK_CYCLES - 2)
		else $error("reset too short");
	a_mr_forces: assert property (mrCnt_reg >= 3 * TICK_CYCLES |-> !hostResetNOeN && !wake)
		else $error("manual reset missed");
	a_meas_start: assert property ($rose(host_reset_n) |-> ##[1:3] measEn) else $error("no measure");
endmodule // wwt_chk
`default_nettype wire

// file: wwt_host_model.sv
// wwt_host_model.sv: sleeping host that answers each wake on doneIn in modes 0 and 1
// assumes mode and dly change only between wake pulses
`timescale 1ns/1ps
`default_nettype none
module wwt_host_model (
	input wire logic mclk,
	input wire logic wake,
	input wire logic [1:0] mode,
	input wire logic [7:0] dly,
	output logic doneIn
);
	// mode 0 one ack, 1 two acks, 2 a static high level with no edge
	initial begin
		doneIn = 1'b0;
		forever begin
			@(posedge mclk);
			if (mode == 2'h2) begin
				doneIn <= 1'b1;
			end else if (wake) begin
				repeat (dly) @(posedge mclk);
				repeat (mode + 1) begin
					doneIn <= 1'b1;
					repeat (3) @(posedge mclk);
					doneIn <= 1'b0;
					repeat (3) @(posedge mclk);
				end
				wait (!wake);
			end else begin
				doneIn <= 1'b0;
			end
		end
	end
endmodule // wwt_host_model
`default_nettype wire

// file: wwt_map.vh
// wwt_map.vh: timing constants of the wake-up watchdog timer
// assumes a 20 MHz mclk and a 10 ms internal time base (tick)
`ifndef WWT_MAP_VH
`define WWT_MAP_VH

// clock and time base
`define WWT_CLK_NS 50
`define WWT_OSC_NS 10000000
`define WWT_TICK_CYCLES ((`WWT_OSC_NS) / (`WWT_CLK_NS))
`define WWT_TICK_W 18
`define WWT_OSC_MS 10

// times in ms, as printed; the longest interval in s
`define WWT_WAKE_MS 20
`define WWT_RST_MS 320
`define WWT_GUARD_MS 20
`define WWT_DB_MS 20
`define WWT_MEAS_MAX_MS 120
`define WWT_IVL_MIN_MS 100
`define WWT_IVL_MAX_S 7200

// the same times in ticks
`define WWT_WAKE_TICKS ((`WWT_WAKE_MS) / (`WWT_OSC_MS))
`define WWT_RST_TICKS ((`WWT_RST_MS) / (`WWT_OSC_MS))
`define WWT_GUARD_TICKS ((`WWT_GUARD_MS + `WWT_OSC_MS - 1) / (`WWT_OSC_MS))
`define WWT_DB_TICKS ((`WWT_DB_MS + `WWT_OSC_MS - 1) / (`WWT_OSC_MS))
`define WWT_MEAS_MAX_TICKS ((`WWT_MEAS_MAX_MS) / (`WWT_OSC_MS))
`define WWT_IVL_MIN_TICKS ((`WWT_IVL_MIN_MS) / (`WWT_OSC_MS))
`define WWT_IVL_MAX_TICKS ((`WWT_IVL_MAX_S * 1000) / (`WWT_OSC_MS))

// counter width for intervals in ticks
`define WWT_IVL_W 20

`endif

// file: wwt_mr_filter.v
// wwt_mr_filter: debounces the manual-reset level on the shared pin
// assumes tick is a one-cycle pulse every 10 ms, pin synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "wwt_map.vh"

module wwt_mr_filter (
	input wire mclk,
	input wire host_reset_n,
	input wire ce,
	input wire tick,
	input wire mrPin,
	output reg mrHeld
);

	// last tick sample of the pin
	reg prevSmp_reg;

	// two consecutive high samples lie 10 ms apart, so any hold of 20 ms is caught;
	// a glitch that misses one sample is rejected
	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			prevSmp_reg <= 1'b0;
			mrHeld <= 1'b0;
		end else if (ce && tick) begin
			prevSmp_reg <= mrPin;
			if (mrPin && prevSmp_reg)
				mrHeld <= 1'b1;
			else if (!mrPin)
				mrHeld <= 1'b0;
		end
	end

endmodule // wwt_mr_filter

`default_nettype wire

// file: wwt_tick.v
// wwt_tick: divides mclk down to the 10 ms internal time base
// assumes mclk runs continuously; ce freezes the divider
`timescale 1ns/1ps
`default_nettype none
`include "wwt_map.vh"

module wwt_tick #(
	parameter TICK_CYCLES = `WWT_TICK_CYCLES,
	parameter TICK_W = `WWT_TICK_W
) (
	input wire mclk,
	input wire host_reset_n,
	input wire ce,
	output reg tick
);

	reg [TICK_W-1:0] div_reg;

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			div_reg <= {TICK_W{1'b0}};
			tick <= 1'b0;
		end else if (ce) begin
			if (div_reg == TICK_CYCLES[TICK_W-1:0] - 1'b1) begin
				div_reg <= {TICK_W{1'b0}};
				tick <= 1'b1;
			end else begin
				div_reg <= div_reg + 1'b1;
				tick <= 1'b0;
			end
		end
	end

endmodule // wwt_tick

`default_nettype wire

// file: wwt_top.v
// wwt_top: wake-up timer with watchdog and manual reset on a shared pin
// assumes all inputs synchronous to mclk; the analog resistor converter
// sits outside and reports the interval in 10 ms ticks on measCode
`timescale 1ns/1ps
`default_nettype none
`include "wwt_map.vh"

module wwt_top #(
	parameter TICK_CYCLES = `WWT_TICK_CYCLES,
	parameter IVL_W = `WWT_IVL_W
) (
	input wire mclk,
	input wire host_reset_n,
	input wire ce,
	input wire doneIn,
	input wire mrPin,
	input wire measDone,
	input wire [IVL_W-1:0] measCode,
	output reg wake,
	output wire hostResetNOut,
	output reg hostResetNOeN,
	output reg measEn,
	output wire pinToDigital
);

	localparam [3:0] ST_MEAS = 4'h1;
	localparam [3:0] ST_RST = 4'h2;
	localparam [3:0] ST_RUN = 4'h4;
	localparam [3:0] ST_MRST = 4'h8;

	localparam [IVL_W-1:0] WAKE_T = `WWT_WAKE_TICKS;
	localparam [IVL_W-1:0] RST_T = `WWT_RST_TICKS;
	localparam [IVL_W-1:0] GUARD_T = `WWT_GUARD_TICKS;
	localparam [IVL_W-1:0] DB_T = `WWT_DB_TICKS;
	localparam [IVL_W-1:0] MEAS_T = `WWT_MEAS_MAX_TICKS;
	localparam [IVL_W-1:0] IVL_MIN = `WWT_IVL_MIN_TICKS;
	localparam [IVL_W-1:0] IVL_MAX = `WWT_IVL_MAX_TICKS;

	wire tick;
	wire mrHeld;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [IVL_W-1:0] cnt_reg;
	reg [IVL_W-1:0] cnt_next;
	reg [IVL_W-1:0] ivlCnt_reg;
	reg [IVL_W-1:0] ivlCnt_next;
	reg [IVL_W-1:0] ivl_reg;
	reg [IVL_W-1:0] ivl_next;
	reg [IVL_W-1:0] wakeCnt_reg;
	reg [IVL_W-1:0] wakeCnt_next;
	reg measured_reg;
	reg measured_next;
	reg armed_reg;
	reg armed_next;
	reg ackSeen_reg;
	reg ackSeen_next;
	reg doneQ_reg;
	reg wake_next;
	reg drive_next;
	reg measEn_next;
	reg [IVL_W-1:0] clampCode;
	wire [IVL_W-1:0] ivlLast;
	wire [IVL_W-1:0] ackLimit;
	wire ivlEnd;
	wire ackNow;

	wwt_tick #(
		.TICK_CYCLES(TICK_CYCLES),
		.TICK_W(`WWT_TICK_W)
	) uTick (
		.mclk(mclk),
		.host_reset_n(host_reset_n),
		.ce(ce),
		.tick(tick)
	);

	wwt_mr_filter uMrFilter (
		.mclk(mclk),
		.host_reset_n(host_reset_n),
		.ce(ce),
		.tick(tick),
		.mrPin(mrPin),
		.mrHeld(mrHeld)
	);

	// open drain: only ever pulls low, the pull-up makes the high level
	assign hostResetNOut = 1'b0;
	assign pinToDigital = ~measEn;

	// ivl_reg never drops below the minimum, so neither difference wraps
	assign ivlLast = ivl_reg - 1'b1;
	assign ackLimit = ivl_reg - GUARD_T;
	assign ivlEnd = (ivlCnt_reg == ivlLast);
	// an edge counts only until GUARD_T ticks before the deadline
	assign ackNow = doneIn && !doneQ_reg
		&& armed_reg && !ackSeen_reg
		&& (ivlCnt_reg < ackLimit)
		&& (state_reg == ST_RUN);

	// out-of-range codes are pulled to the nearest legal interval
	always @* begin
		if (measCode < IVL_MIN)
			clampCode = IVL_MIN;
		else if (measCode > IVL_MAX)
			clampCode = IVL_MAX;
		else
			clampCode = measCode;
	end

	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		ivlCnt_next = ivlCnt_reg;
		ivl_next = ivl_reg;
		wakeCnt_next = wakeCnt_reg;
		measured_next = measured_reg;
		armed_next = armed_reg;
		ackSeen_next = ackSeen_reg;
		wake_next = wake;
		drive_next = ~hostResetNOeN;
		measEn_next = measEn;
		case (state_reg)
		ST_MEAS: begin
			drive_next = 1'b1;
			wake_next = 1'b0;
			measEn_next = 1'b1;
			if (tick)
				cnt_next = cnt_reg + 1'b1;
			// converter result, or give up at the longest conversion time
			if (measDone || (tick && cnt_reg == MEAS_T - 1'b1)) begin
				ivl_next = clampCode;
				measured_next = 1'b1;
				measEn_next = 1'b0;
				cnt_next = {IVL_W{1'b0}};
				state_next = ST_RST;
			end
		end
		ST_RST: begin
			drive_next = 1'b1;
			wake_next = 1'b0;
			if (tick) begin
				if (cnt_reg == RST_T - 1'b1) begin
					// interval starts at reset release without a wake
					drive_next = 1'b0;
					cnt_next = {IVL_W{1'b0}};
					ivlCnt_next = {IVL_W{1'b0}};
					armed_next = 1'b0;
					ackSeen_next = 1'b0;
					state_next = ST_RUN;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
		end
		ST_RUN: begin
			if (tick && wake) begin
				if (wakeCnt_reg == WAKE_T - 1'b1)
					wake_next = 1'b0;
				else
					wakeCnt_next = wakeCnt_reg + 1'b1;
			end
			if (tick) begin
				if (ivlEnd) begin
					ivlCnt_next = {IVL_W{1'b0}};
					if (armed_reg && !ackSeen_reg) begin
						// watchdog expired: no wake, reset instead
						drive_next = 1'b1;
						wake_next = 1'b0;
						cnt_next = {IVL_W{1'b0}};
						armed_next = 1'b0;
						state_next = ST_RST;
					end else begin
						wake_next = 1'b1;
						wakeCnt_next = {IVL_W{1'b0}};
						armed_next = 1'b1;
						ackSeen_next = 1'b0;
					end
				end else begin
					ivlCnt_next = ivlCnt_reg + 1'b1;
				end
			end
			// an acknowledge clears the watchdog and ends the wake pulse, never ivlCnt
			if (ackNow) begin
				ackSeen_next = 1'b1;
				wake_next = 1'b0;
			end
		end
		ST_MRST: begin
			drive_next = 1'b1;
			wake_next = 1'b0;
			measEn_next = 1'b0;
			if (mrHeld) begin
				cnt_next = {IVL_W{1'b0}};
			end else if (!measured_reg) begin
				// interrupted conversion starts over on release
				cnt_next = {IVL_W{1'b0}};
				state_next = ST_MEAS;
			end else if (tick) begin
				// debounce time after release, then one reset pulse width
				if (cnt_reg == DB_T - 1'b1) begin
					cnt_next = {IVL_W{1'b0}};
					state_next = ST_RST;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
		end
		default: begin
			state_next = ST_MEAS;
			cnt_next = {IVL_W{1'b0}};
			drive_next = 1'b1;
			wake_next = 1'b0;
		end
		endcase
		// manual reset overrides every state, including the measurement
		if (mrHeld && state_reg != ST_MRST) begin
			state_next = ST_MRST;
			cnt_next = {IVL_W{1'b0}};
			ivlCnt_next = {IVL_W{1'b0}};
			wakeCnt_next = {IVL_W{1'b0}};
			armed_next = 1'b0;
			ackSeen_next = 1'b0;
			wake_next = 1'b0;
			drive_next = 1'b1;
			measEn_next = 1'b0;
		end
	end

	// every register below freezes while ce is low
	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			state_reg <= ST_MEAS;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			cnt_reg <= {IVL_W{1'b0}};
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			ivlCnt_reg <= {IVL_W{1'b0}};
		end else if (ce) begin
			ivlCnt_reg <= ivlCnt_next;
		end
	end

	// the shortest interval stands until a conversion result arrives or the measurement times out
	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			ivl_reg <= IVL_MIN;
		end else if (ce) begin
			ivl_reg <= ivl_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			wakeCnt_reg <= {IVL_W{1'b0}};
		end else if (ce) begin
			wakeCnt_reg <= wakeCnt_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			measured_reg <= 1'b0;
		end else if (ce) begin
			measured_reg <= measured_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			armed_reg <= 1'b0;
		end else if (ce) begin
			armed_reg <= armed_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			ackSeen_reg <= 1'b0;
		end else if (ce) begin
			ackSeen_reg <= ackSeen_next;
		end
	end

	// sampled only on working edges, so a frozen clock hides no edge
	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			doneQ_reg <= 1'b0;
		end else if (ce) begin
			doneQ_reg <= doneIn;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			wake <= 1'b0;
		end else if (ce) begin
			wake <= wake_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			hostResetNOeN <= 1'b0;
		end else if (ce) begin
			hostResetNOeN <= ~drive_next;
		end
	end

	always @(posedge mclk or negedge host_reset_n) begin
		if (!host_reset_n) begin
			measEn <= 1'b0;
		end else if (ce) begin
			measEn <= measEn_next;
		end
	end

endmodule // wwt_top

`default_nettype wire
